// ===== hw/dptr_modes.sv
// Purpose: dual data pointer address generation and update modes
// Assumes: core presents one pointer operation per cycle at most
// Notes: registers reached over AXI4-Lite, answers registered
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps

module dptr_modes #(
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire dptr_pkg::op_s op,
  output dptr_pkg::acc_s acc_out
);

  // ==========================================================
  // Register state
  logic [7:0] cfg_r;
  logic [7:0] mode_r;
  logic [7:0] len_r;
  logic sel_r;
  logic [15:0] ptr_r [2];

  // ==========================================================
  // Bus slave state
  logic aw_got_r;
  logic w_got_r;
  logic [9:0] widx_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic wr_hit;
  logic [9:0] ridx;
  logic rd_hit;
  logic [31:0] rd_val;

  // ==========================================================
  // Operation decode
  logic tgt;
  logic is_mem;
  logic is_inc;
  logic [15:0] ptr_t;
  logic [15:0] len_a;
  logic [15:0] len_b;

  // Region tops; len 0xFF still fits below the next region
  assign len_a = dptr_pkg::REGION_A + {8'h00, len_r};
  assign len_b = dptr_pkg::REGION_B + {8'h00, len_r};

  // Select bit swaps primary and alternate references
  assign tgt = op.alt ^ sel_r;
  assign is_mem = op.valid && (op.kind != dptr_pkg::OP_INC);
  assign is_inc = op.valid && (op.kind == dptr_pkg::OP_INC);
  assign ptr_t = ptr_r[tgt];

  // Next pointer value with circular wrap at region edges
  function automatic logic [15:0] step(
    input logic [15:0] p,
    input logic dn,
    input logic circ,
    input logic [15:0] top_a,
    input logic [15:0] top_b
  );
    logic [15:0] r;
    r = dn ? p - 16'h0001 : p + 16'h0001;
    if (circ && !dn) begin
      if (p == top_a) begin
        r = dptr_pkg::REGION_A;
      end else if (p == top_b) begin
        r = dptr_pkg::REGION_B;
      end
    end else if (circ && dn) begin
      if (p == dptr_pkg::REGION_A) begin
        r = top_a;
      end else if (p == dptr_pkg::REGION_B) begin
        r = top_b;
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Pointer registers, one per pointer
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_ptr
      logic upd;
      logic dn;
      logic circ;
      logic hit_g;
      logic [15:0] nxt;
      logic [9:0] my_idx;
      assign upd = (g == 1) ? cfg_r[dptr_pkg::CFG_UPD1]
                            : cfg_r[dptr_pkg::CFG_UPD0];
      assign dn = (g == 1) ? cfg_r[dptr_pkg::CFG_DIR1]
                           : cfg_r[dptr_pkg::CFG_DIR0];
      assign circ = (g == 1) ? mode_r[dptr_pkg::MODE_CIRC1]
                             : mode_r[dptr_pkg::MODE_CIRC0];
      assign my_idx = (g == 1) ? dptr_pkg::IDX_PTR1
                               : dptr_pkg::IDX_PTR0;
      assign hit_g = (tgt == 1'(g));
      assign nxt = step(ptr_r[g], dn, circ, len_a, len_b);
      // Bus writes win over a core update in the same cycle
      always_ff @(posedge clk) begin
        if (!rstn) begin
          ptr_r[g] <= dptr_pkg::PTR_RST;
        end else if (wr_fire && widx_r == my_idx) begin
          if (wstrb_r[0]) begin
            ptr_r[g][7:0] <= wdata_r[7:0];
          end
          if (wstrb_r[1]) begin
            ptr_r[g][15:8] <= wdata_r[15:8];
          end
        end else if (hit_g && is_mem && upd) begin
          ptr_r[g] <= nxt;
        end else if (hit_g && is_inc) begin
          ptr_r[g] <= nxt;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Address and data-register answer to the core
  // Index is always the accumulator; the B redirect never feeds it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_out <= '0;
    end else begin
      acc_out.valid <= is_mem;
      acc_out.use_b <= is_mem && tgt
                       && mode_r[dptr_pkg::MODE_RB];
      if (op.kind == dptr_pkg::OP_CODE
          && !mode_r[dptr_pkg::MODE_CD]) begin
        acc_out.addr <= ptr_t + {8'h00, op.acc};
      end else begin
        acc_out.addr <= ptr_t;
      end
    end
  end

  // ==========================================================
  // Write channel: address and data taken in either order
  assign wr_fire = aw_got_r && w_got_r && !bvalid;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= dptr_pkg::RESP_OKAY;
      widx_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        awready <= 1'b0;
        widx_r <= awaddr[11:2];
      end
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        wready <= 1'b0;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? dptr_pkg::RESP_OKAY
                        : dptr_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Write decode
  always_comb begin
    if (widx_r == dptr_pkg::IDX_CFG) begin
      wr_hit = 1'b1;
    end else if (widx_r == dptr_pkg::IDX_SEL) begin
      wr_hit = 1'b1;
    end else if (widx_r == dptr_pkg::IDX_MODE) begin
      wr_hit = 1'b1;
    end else if (widx_r == dptr_pkg::IDX_LEN) begin
      wr_hit = 1'b1;
    end else if (widx_r == dptr_pkg::IDX_PTR0) begin
      wr_hit = 1'b1;
    end else if (widx_r == dptr_pkg::IDX_PTR1) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Control registers; only the documented bits are kept
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_r <= dptr_pkg::CFG_RST;
      mode_r <= dptr_pkg::MODE_RST;
      len_r <= dptr_pkg::LEN_RST;
      sel_r <= dptr_pkg::SEL_RST;
    end else if (wr_fire && wstrb_r[0]) begin
      if (widx_r == dptr_pkg::IDX_CFG) begin
        cfg_r <= wdata_r[7:0] & dptr_pkg::CFG_WMASK;
      end else if (widx_r == dptr_pkg::IDX_MODE) begin
        mode_r <= wdata_r[7:0] & dptr_pkg::MODE_WMASK;
      end else if (widx_r == dptr_pkg::IDX_LEN) begin
        len_r <= wdata_r[7:0];
      end else if (widx_r == dptr_pkg::IDX_SEL) begin
        sel_r <= wdata_r[dptr_pkg::SEL_BIT];
      end
    end
  end

  // ==========================================================
  // Read channel: answer one cycle after the address is taken
  assign ridx = araddr[11:2];
  always_comb begin
    rd_hit = 1'b1;
    rd_val = '0;
    if (ridx == dptr_pkg::IDX_CFG) begin
      rd_val[7:0] = cfg_r;
    end else if (ridx == dptr_pkg::IDX_SEL) begin
      rd_val[dptr_pkg::SEL_BIT] = sel_r;
    end else if (ridx == dptr_pkg::IDX_MODE) begin
      rd_val[7:0] = mode_r;
    end else if (ridx == dptr_pkg::IDX_LEN) begin
      rd_val[7:0] = len_r;
    end else if (ridx == dptr_pkg::IDX_PTR0) begin
      rd_val[15:0] = ptr_r[0];
    end else if (ridx == dptr_pkg::IDX_PTR1) begin
      rd_val[15:0] = ptr_r[1];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= dptr_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= rd_hit ? dptr_pkg::RESP_OKAY
                      : dptr_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ==========================================================
  // Assertions
  localparam int CFG_U0 = dptr_pkg::CFG_UPD0;
  localparam int CFG_U1 = dptr_pkg::CFG_UPD1;
  localparam int CFG_D0 = dptr_pkg::CFG_DIR0;
  localparam int CFG_D1 = dptr_pkg::CFG_DIR1;
  localparam int CIRC0_B = dptr_pkg::MODE_CIRC0;
  localparam int CIRC1_B = dptr_pkg::MODE_CIRC1;
  localparam int MODE_RB_B = dptr_pkg::MODE_RB;
  localparam int MODE_CD_B = dptr_pkg::MODE_CD;
  logic quiet;
  assign quiet = !wr_fire;

  a_upd0_inc: assert property (@(posedge clk) disable iff (!rstn)
    is_mem && !tgt && cfg_r[CFG_U0] && !cfg_r[CFG_D0]
    && !mode_r[CIRC0_B] && quiet
    |=> ptr_r[0] == $past(ptr_r[0]) + 16'h0001)
    else $error("pointer 0 post increment missing");
  a_upd1_hold: assert property (@(posedge clk) disable iff (!rstn)
    is_mem && tgt && !cfg_r[CFG_U1] && quiet
    |=> $stable(ptr_r[1]))
    else $error("pointer 1 moved without update enable");
  a_inc1_down: assert property (@(posedge clk) disable iff (!rstn)
    is_inc && tgt && cfg_r[CFG_D1] && !mode_r[CIRC1_B] && quiet
    |=> ptr_r[1] == $past(ptr_r[1]) - 16'h0001)
    else $error("pointer 1 increment not reversed");
  a_inc0_up: assert property (@(posedge clk) disable iff (!rstn)
    is_inc && !tgt && !cfg_r[CFG_D0] && !mode_r[CIRC0_B] && quiet
    |=> ptr_r[0] == $past(ptr_r[0]) + 16'h0001)
    else $error("pointer 0 increment wrong");
  a_redirect_b: assert property (@(posedge clk) disable iff (!rstn)
    is_mem |=> acc_out.use_b == $past(tgt && mode_r[MODE_RB_B]))
    else $error("B redirect wrong");
  a_index_off: assert property (@(posedge clk) disable iff (!rstn)
    is_mem && op.kind == dptr_pkg::OP_CODE && mode_r[MODE_CD_B]
    |=> acc_out.addr == $past(ptr_t))
    else $error("indexed read not disabled");
  a_wrap_up: assert property (@(posedge clk) disable iff (!rstn)
    is_inc && !tgt && !cfg_r[CFG_D0] && mode_r[CIRC0_B]
    && ptr_r[0] == len_b && quiet
    |=> ptr_r[0] == dptr_pkg::REGION_B)
    else $error("upper region wrap missing");
  a_wrap_down: assert property (@(posedge clk) disable iff (!rstn)
    is_inc && tgt && cfg_r[CFG_D1] && mode_r[CIRC1_B]
    && ptr_r[1] == dptr_pkg::REGION_A && quiet
    |=> ptr_r[1] == $past(len_a))
    else $error("lower region underflow wrong");
  a_rd_answer: assert property (@(posedge clk) disable iff (!rstn)
    arvalid && arready |=> rvalid ##0 !arready)
    else $error("read answer late");

  c_wrap: cover property (@(posedge clk) disable iff (!rstn)
    is_inc && mode_r[CIRC0_B] && ptr_r[0] == len_a);
  c_redirect: cover property (@(posedge clk) disable iff (!rstn)
    is_mem && tgt && mode_r[MODE_RB_B]);
  c_autodec: cover property (@(posedge clk) disable iff (!rstn)
    is_mem && cfg_r[CFG_U1] && cfg_r[CFG_D1]);
  c_wr_rd: cover property (@(posedge clk) disable iff (!rstn)
    bvalid && bready ##[1:4] rvalid && rready);

endmodule

// ===== hw/dptr_pkg.sv
// Purpose: shared constants and types for the dual pointer block
// Assumes: AXI4-Lite register access, one 100 MHz clock
// Notes: register indices are word indices; byte address = index * 4
package dptr_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_CFG = 10'h0A1;
  localparam logic [9:0] IDX_SEL = 10'h0A2;
  localparam logic [9:0] IDX_MODE = 10'h0A3;
  localparam logic [9:0] IDX_LEN = 10'h0E3;
  localparam logic [9:0] IDX_PTR0 = 10'h0F0;
  localparam logic [9:0] IDX_PTR1 = 10'h0F1;

  // ==========================================================
  // Field positions
  localparam int CFG_UPD1 = 7;
  localparam int CFG_UPD0 = 6;
  localparam int CFG_DIR1 = 5;
  localparam int CFG_DIR0 = 4;
  localparam logic [7:0] CFG_WMASK = 8'hF0;
  localparam int MODE_RB = 0;
  localparam int MODE_CD = 1;
  localparam int MODE_CIRC0 = 2;
  localparam int MODE_CIRC1 = 3;
  localparam logic [7:0] MODE_WMASK = 8'h0F;
  localparam int SEL_BIT = 0;

  // ==========================================================
  // Reset values and address constants
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] LEN_RST = 8'h00;
  localparam logic SEL_RST = 1'b0;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] REGION_A = 16'h0000;
  localparam logic [15:0] REGION_B = 16'h0100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Core-side request
  typedef enum logic [1:0] {
    OP_XDATA = 2'h0,
    OP_CODE = 2'h1,
    OP_INC = 2'h3
  } op_kind_e;

  typedef struct packed {
    logic valid;
    op_kind_e kind;
    logic alt;
    logic [7:0] acc;
  } op_s;

  // Core-side answer
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic use_b;
  } acc_s;

endpackage

// ===== tb/dual_data_pointer_modes_tb.sv
// Purpose: self-checking bench for the dual data pointer block
// Assumes: dptr_modes with AXI4-Lite registers and one 100 MHz clock
// Notes: pointers are checked by bus read-back after each upd operation; t_redir checks only the answer
`timescale 1ns/1ps

`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
  end \
end

module dual_data_pointer_modes_tb;
  logic clk;
  logic rstn;
  logic [11:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [11:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  dptr_pkg::op_s op;
  dptr_pkg::acc_s acc_out;
  int errors;
  int checks_done;
  int cycles;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic [1:0] wr_resp;

  // Short names keep scenario lines inside the line width
  localparam logic [9:0] CF = dptr_pkg::IDX_CFG;
  localparam logic [9:0] P0 = dptr_pkg::IDX_PTR0;
  localparam logic [9:0] P1 = dptr_pkg::IDX_PTR1;
  localparam dptr_pkg::op_kind_e XD = dptr_pkg::OP_XDATA;
  localparam dptr_pkg::op_kind_e CD = dptr_pkg::OP_CODE;
  localparam dptr_pkg::op_kind_e IN = dptr_pkg::OP_INC;

  dptr_modes #(.AW(12)) i_dut (
    .clk(clk), .rstn(rstn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .op(op), .acc_out(acc_out)
  );

  // ==========================================================
  // Clock and hang guard
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Run takes well under a thousand cycles; the ceiling leaves margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Bus and core drivers
  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Each channel is released only at the edge that takes it
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk_ptr(input logic [9:0] idx, input logic [15:0] e);
    rd(idx);
    `CHK("pointer", {16'h0000, e}, rd_data)
  endtask

  // One-cycle core request; the answer is judged after it settles
  task automatic mv(input dptr_pkg::op_kind_e k, input logic a,
                    input logic [7:0] ac, input logic [15:0] ea,
                    input logic eb);
    @(posedge clk);
    op <= '{valid: 1'b1, kind: k, alt: a, acc: ac};
    @(posedge clk);
    op <= '0;
    #1;
    if (k == dptr_pkg::OP_INC) begin
      `CHK("no answer", 1'b0, acc_out.valid)
    end else begin
      `CHK("answer", 1'b1, acc_out.valid)
      `CHK("address", ea, acc_out.addr)
      `CHK("use_b", eb, acc_out.use_b)
    end
  endtask

  task automatic upd(input logic [9:0] idx, input logic [15:0] s,
                     input dptr_pkg::op_kind_e k, input logic a,
                     input logic eb, input logic [15:0] e);
    wr(idx, s);
    mv(k, a, 8'h00, s, eb);
    chk_ptr(idx, e);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(dptr_pkg::IDX_CFG);
    `CHK("cfg reset", 32'h0, rd_data)
    rd(dptr_pkg::IDX_MODE);
    `CHK("mode reset", 32'h0, rd_data)
    wr(dptr_pkg::IDX_CFG, 16'h00FF);
    rd(dptr_pkg::IDX_CFG);
    `CHK("cfg low bits", 32'hF0, rd_data)
    wr(dptr_pkg::IDX_LEN, 16'h00A5);
    `CHK("length bresp", dptr_pkg::RESP_OKAY, wr_resp)
    rd(dptr_pkg::IDX_LEN);
    `CHK("length", 32'hA5, rd_data)
    `CHK("length rresp", dptr_pkg::RESP_OKAY, rd_resp)
    // Unmapped place answers with an error and zero data
    rd(10'h010);
    `CHK("unmapped rresp", dptr_pkg::RESP_SLVERR, rd_resp)
    `CHK("unmapped rdata", 32'h0, rd_data)
    wr(10'h010, 16'h1234);
    `CHK("unmapped bresp", dptr_pkg::RESP_SLVERR, wr_resp)
  endtask

  task automatic t_auto;
    wr(CF, 16'h0080);
    upd(P1, 16'h1234, XD, 1, 0, 16'h1235);
    upd(P0, 16'h4000, XD, 0, 0, 16'h4000);
    wr(CF, 16'h0040);
    upd(P0, 16'h4000, XD, 0, 0, 16'h4001);
    wr(CF, 16'h0070);
    upd(P0, 16'h4000, CD, 0, 0, 16'h3FFF);
    upd(P1, 16'h1235, CD, 1, 0, 16'h1235);
  endtask

  task automatic t_inc;
    wr(CF, 16'h0000);
    upd(P1, 16'h12FF, IN, 1, 0, 16'h1300);
    upd(P0, 16'h3FFF, IN, 0, 0, 16'h4000);
    wr(CF, 16'h0030);
    upd(P1, 16'h1300, IN, 1, 0, 16'h12FF);
    upd(P0, 16'h4000, IN, 0, 0, 16'h3FFF);
    wr(CF, 16'h0000);
  endtask

  // Pointer 1 holds 12FF and pointer 0 holds 3FFF from here on
  task automatic t_redir;
    wr(dptr_pkg::IDX_MODE, 16'h0001);
    mv(dptr_pkg::OP_XDATA, 1, 8'h00, 16'h12FF, 1);
    mv(dptr_pkg::OP_XDATA, 0, 8'h00, 16'h3FFF, 0);
    wr(dptr_pkg::IDX_SEL, 16'h0001);
    mv(dptr_pkg::OP_XDATA, 0, 8'h00, 16'h12FF, 1);
    mv(dptr_pkg::OP_XDATA, 1, 8'h00, 16'h3FFF, 0);
    mv(dptr_pkg::OP_CODE, 0, 8'h10, 16'h130F, 1);
    wr(dptr_pkg::IDX_MODE, 16'h0003);
    mv(dptr_pkg::OP_CODE, 0, 8'h10, 16'h12FF, 1);
    mv(dptr_pkg::OP_CODE, 1, 8'h10, 16'h3FFF, 0);
    wr(dptr_pkg::IDX_MODE, 16'h0000);
    mv(dptr_pkg::OP_CODE, 1, 8'h10, 16'h400F, 0);
    wr(dptr_pkg::IDX_SEL, 16'h0000);
  endtask

  // Region tops are 000F and 010F with a length of 0F
  task automatic t_circ;
    wr(dptr_pkg::IDX_LEN, 16'h000F);
    wr(dptr_pkg::IDX_MODE, 16'h0004);
    upd(P0, 16'h000F, IN, 0, 0, 16'h0000);
    upd(P0, 16'h010F, IN, 0, 0, 16'h0100);
    upd(P0, 16'h0050, IN, 0, 0, 16'h0051);
    upd(P0, 16'h0110, IN, 0, 0, 16'h0111);
    upd(P1, 16'h000F, IN, 1, 0, 16'h0010);
    wr(CF, 16'h0010);
    upd(P0, 16'h0000, IN, 0, 0, 16'h000F);
    upd(P0, 16'h0100, IN, 0, 0, 16'h010F);
    // Pointer 1 alone in circular mode, advanced by auto update
    wr(dptr_pkg::IDX_MODE, 16'h0008);
    wr(CF, 16'h0080);
    upd(P1, 16'h010F, XD, 1, 0, 16'h0100);
    upd(P0, 16'h000F, IN, 0, 0, 16'h0010);
    // Largest length: 256 entries per region
    wr(dptr_pkg::IDX_LEN, 16'h00FF);
    upd(P1, 16'h01FF, XD, 1, 0, 16'h0100);
    wr(CF, 16'h00A0);
    upd(P1, 16'h0000, CD, 1, 0, 16'h00FF);
    // Explicit decrement of pointer 1 below the lower base
    wr(CF, 16'h0020);
    upd(P1, 16'h0000, IN, 1, 0, 16'h00FF);
  endtask

  // ==========================================================
  // Closing report, reached from the main sequence or the guard
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence: inputs idle at time zero, reset for two cycles
  initial begin
    errors = 0;
    checks_done = 0;
    cycles = 0;
    rstn = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = '0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    op = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_auto();
    t_inc();
    t_redir();
    t_circ();
    tally_and_finish();
  end
endmodule
